// [core/adm_pkg.sv]
// Package for the audio converter mode control register bank
package adm_pkg;

  // Control word as it arrives from the serial control port
  typedef struct packed {
    logic       rw;
    logic [6:0] index;
    logic [7:0] data;
  } adm_word_type;

  // Static mode bits decoded from the remaining control registers
  typedef struct packed {
    logic       output_phase_invert;
    logic       converter_disable;
    logic       zero_flag_pin_select;
    logic       bypass_stereo_select;
    logic       rolloff_select;
    logic       zero_detect_mute_enable;
    logic       one_bit_stream_mode;
    logic       filter_bypass;
    logic       mono_enable;
    logic       mono_channel_select;
    logic [1:0] modulator_rate_select;
    logic [1:0] stream_zero_output_enable;
    logic       pcm_zero_output_enable;
  } adm_mode_type;

  // Register indices
  localparam logic [6:0] ADM_IDX_LEFT_ATTEN  = 7'h10;
  localparam logic [6:0] ADM_IDX_RIGHT_ATTEN = 7'h11;
  localparam logic [6:0] ADM_IDX_FORMAT      = 7'h12;
  localparam logic [6:0] ADM_IDX_OUTPUT      = 7'h13;
  localparam logic [6:0] ADM_IDX_SYSTEM      = 7'h14;
  localparam logic [6:0] ADM_IDX_ZERO_OUT    = 7'h15;
  localparam logic [6:0] ADM_IDX_ZERO_FLAGS  = 7'h16;
  localparam int         ADM_NUM_RW         = 6;

  // Reset values of the writable registers, indexed from the first one
  localparam logic [7:0] ADM_RESET_VALS [0:5] =
    '{8'hff, 8'hff, 8'h50, 8'h00, 8'h00, 8'h01};
  // Bits that a write may change; reserved and write-only bits excluded
  localparam logic [7:0] ADM_WMASK_SYSTEM   = 8'h3f;
  localparam logic [7:0] ADM_WMASK_ZERO_OUT = 8'h07;
  localparam logic [7:0] ADM_WMASK_FULL     = 8'hff;

  // Field positions, format and de-emphasis register
  localparam int ADM_POS_LOAD_EN  = 7;
  localparam int ADM_POS_FORMAT      = 4;
  localparam int ADM_POS_DEEMPH_RATE = 2;
  localparam int ADM_POS_DEEMPH_EN   = 1;
  localparam int ADM_POS_MUTE        = 0;
  // Output and filter register
  localparam int ADM_POS_PHASE_INV   = 7;
  localparam int ADM_POS_STEP_RATE   = 5;
  localparam int ADM_POS_CONV_DIS    = 4;
  localparam int ADM_POS_ZPIN_SEL    = 3;
  localparam int ADM_POS_BYP_STEREO  = 2;
  localparam int ADM_POS_ROLLOFF     = 1;
  localparam int ADM_POS_ZMUTE_EN    = 0;
  // System register
  localparam int ADM_POS_SOFT_RST    = 6;
  localparam int ADM_POS_STREAM      = 5;
  localparam int ADM_POS_FILT_BYP    = 4;
  localparam int ADM_POS_MONO        = 3;
  localparam int ADM_POS_MONO_CH     = 2;
  localparam int ADM_POS_MOD_RATE    = 0;
  // Zero output register
  localparam int ADM_POS_STREAM_ZERO = 1;
  localparam int ADM_POS_PCM_ZERO    = 0;

  // Attenuation codes
  localparam logic [7:0] ADM_ATTEN_MAX_CODE  = 8'hff;
  localparam logic [7:0] ADM_ATTEN_MIN_FINITE = 8'h0f;
  localparam logic [7:0] ADM_RAMP_MUTE_LEVEL = 8'h00;
  localparam logic [2:0] ADM_FORMAT_FIRST_RESERVED = 3'h6;

endpackage

// [core/adm_mode_registers.sv]
// Mode control register bank with attenuators and soft mute ramp
// Function
// - Top word bit set reads, clear writes
// - Zero flag register ignores every write
// - Word holds seven bit index, eight data
// - Two attenuation codes, reset to all ones
// - Attenuation is half dB per code below 255
// - Code fifteen gives minus 120 dB
// - Codes zero to fourteen mute the channel
// - Load enable low ignores new codes
// - Load enable high transfers written codes
// - Three bit format select, default 24-bit I2S
// - Filter bypass gives format other meaning
// - Two bit de-emphasis rate, default disabled
// - Rate applies only while enable bit set
// - Stream mode reuses rate as FIR setting
// - De-emphasis enable bit, default off
// - Soft mute ramps 255 steps to mute
// - Step every 1, 2, 4, 8 word periods
// - Zero flags read one when zero detected
`timescale 1ns/100ps
module adm_mode_registers (
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_word_valid,
  input  wire adm_pkg::adm_word_type i_word,
  input  wire logic                 i_word_clk_tick,
  input  wire logic                 i_left_zero,
  input  wire logic                 i_right_zero,
  output logic                      o_rd_valid,
  output logic [7:0]                o_rd_data,
  output logic [7:0]                o_left_level,
  output logic [7:0]                o_right_level,
  output logic [7:0]                o_left_atten_halfdb,
  output logic [7:0]                o_right_atten_halfdb,
  output logic                      o_left_mute,
  output logic                      o_right_mute,
  output logic [2:0]                o_audio_format_select,
  output logic                      o_format_reserved,
  output logic                      o_ext_filter_format_mode,
  output logic                      o_deemph_active,
  output logic [1:0]                o_deemph_rate_select,
  output logic [1:0]                o_fir_perf_select,
  output logic                      o_soft_reset_pulse,
  output adm_pkg::adm_mode_type     o_mode
);

  logic [7:0] bank_reg [0:5];
  logic [7:0] applied_reg [0:1];
  logic [7:0] ramp_reg [0:1];
  logic [2:0] div_cnt_reg;
  logic       soft_reset_reg;
  logic       rd_valid_reg;
  logic [7:0] rd_data_reg;

  logic       wr_req;
  logic       rd_req;
  logic       wr_hit;
  logic       soft_reset_req;
  logic [2:0] slot;
  logic       load_en;
  logic       mute_req;
  logic [1:0] step_rate;
  logic [2:0] div_term;
  logic       step_en;
  logic [7:0] reg18;
  logic [7:0] reg19;
  logic [7:0] reg20;
  logic [7:0] reg21;

  // Slot of a writable register, valid only for indices 16 to 21
  function automatic logic [2:0] bank_slot(input logic [6:0] idx);
    logic [6:0] off;
    off = idx - adm_pkg::ADM_IDX_LEFT_ATTEN;
    return off[2:0];
  endfunction

  function automatic logic [7:0] write_mask(input logic [6:0] idx);
    logic [7:0] m;
    m = adm_pkg::ADM_WMASK_FULL;
    if (idx == adm_pkg::ADM_IDX_SYSTEM) begin
      m = adm_pkg::ADM_WMASK_SYSTEM;
    end else if (idx == adm_pkg::ADM_IDX_ZERO_OUT) begin
      m = adm_pkg::ADM_WMASK_ZERO_OUT;
    end
    return m;
  endfunction

  // Terminal count of the step divider: 0, 1, 3 or 7 extra word periods
  function automatic logic [2:0] step_term(input logic [1:0] rate);
    logic [3:0] t;
    t = (4'h1 << rate) - 4'h1;
    return t[2:0];
  endfunction

  function automatic logic [7:0] halfdb(input logic [7:0] level);
    return adm_pkg::ADM_ATTEN_MAX_CODE - level;
  endfunction

  assign reg18 = bank_reg[2];
  assign reg19 = bank_reg[3];
  assign reg20 = bank_reg[4];
  assign reg21 = bank_reg[5];

  assign wr_req  = i_word_valid && !i_word.rw;
  assign rd_req  = i_word_valid && i_word.rw;
  // Index 22 falls outside the writable range, so writes to it vanish
  assign wr_hit  = wr_req && (i_word.index >= adm_pkg::ADM_IDX_LEFT_ATTEN)
                   && (i_word.index <= adm_pkg::ADM_IDX_ZERO_OUT);
  assign slot    = bank_slot(i_word.index);
  assign soft_reset_req = wr_req
                   && (i_word.index == adm_pkg::ADM_IDX_SYSTEM)
                   && i_word.data[adm_pkg::ADM_POS_SOFT_RST];
  assign load_en  = reg18[adm_pkg::ADM_POS_LOAD_EN];
  assign mute_req = reg18[adm_pkg::ADM_POS_MUTE];
  assign step_rate = reg19[adm_pkg::ADM_POS_STEP_RATE +: 2];
  assign div_term  = step_term(step_rate);
  assign step_en  = i_word_clk_tick && (div_cnt_reg == div_term);

  // Register storage; soft reset restores every default in one edge
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < adm_pkg::ADM_NUM_RW; i++) begin
        bank_reg[i] <= adm_pkg::ADM_RESET_VALS[i];
      end
    end else if (soft_reset_req) begin
      for (int i = 0; i < adm_pkg::ADM_NUM_RW; i++) begin
        bank_reg[i] <= adm_pkg::ADM_RESET_VALS[i];
      end
    end else if (wr_hit) begin
      bank_reg[slot] <= i_word.data & write_mask(i_word.index);
    end
  end

  // The write-only reset bit never stores; it makes one pulse here
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= soft_reset_req;
    end
  end

  // Codes reach the attenuators only when loading is enabled at write
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      applied_reg[0] <= adm_pkg::ADM_RESET_VALS[0];
      applied_reg[1] <= adm_pkg::ADM_RESET_VALS[1];
    end else if (soft_reset_req) begin
      applied_reg[0] <= adm_pkg::ADM_RESET_VALS[0];
      applied_reg[1] <= adm_pkg::ADM_RESET_VALS[1];
    end else if (wr_hit && load_en && (slot < 3'h2)) begin
      applied_reg[slot[0]] <= i_word.data;
    end
  end

  // Word period divider for the ramp step rate
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_cnt_reg <= 3'h0;
    end else if (soft_reset_req) begin
      div_cnt_reg <= 3'h0;
    end else if (i_word_clk_tick) begin
      div_cnt_reg <= (div_cnt_reg >= div_term) ? 3'h0
                     : div_cnt_reg + 3'h1;
    end
  end

  // Ramp walks one code per step toward the target, so both level
  // changes and soft mute are click free; a full ramp takes 255 steps
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ramp_reg[0] <= adm_pkg::ADM_RESET_VALS[0];
      ramp_reg[1] <= adm_pkg::ADM_RESET_VALS[1];
    end else if (soft_reset_req) begin
      ramp_reg[0] <= adm_pkg::ADM_RESET_VALS[0];
      ramp_reg[1] <= adm_pkg::ADM_RESET_VALS[1];
    end else if (step_en) begin
      for (int c = 0; c < 2; c++) begin
        if (mute_req) begin
          if (ramp_reg[c] != adm_pkg::ADM_RAMP_MUTE_LEVEL) begin
            ramp_reg[c] <= ramp_reg[c] - 8'h01;
          end
        end else if (ramp_reg[c] < applied_reg[c]) begin
          ramp_reg[c] <= ramp_reg[c] + 8'h01;
        end else if (ramp_reg[c] > applied_reg[c]) begin
          ramp_reg[c] <= ramp_reg[c] - 8'h01;
        end
      end
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= 8'h00;
    end else begin
      rd_valid_reg <= rd_req;
      if (rd_req) begin
        if (i_word.index == adm_pkg::ADM_IDX_ZERO_FLAGS) begin
          rd_data_reg <= {6'h00, i_right_zero, i_left_zero};
        end else if (wr_hit || ((i_word.index >= adm_pkg::ADM_IDX_LEFT_ATTEN)
                     && (i_word.index <= adm_pkg::ADM_IDX_ZERO_OUT))) begin
          rd_data_reg <= bank_reg[slot];
        end else begin
          rd_data_reg <= 8'h00;
        end
      end
    end
  end

  assign o_rd_valid         = rd_valid_reg;
  assign o_rd_data          = rd_data_reg;
  assign o_soft_reset_pulse = soft_reset_reg;
  assign o_left_level       = ramp_reg[0];
  assign o_right_level      = ramp_reg[1];
  assign o_left_atten_halfdb  = halfdb(ramp_reg[0]);
  assign o_right_atten_halfdb = halfdb(ramp_reg[1]);
  assign o_left_mute  = ramp_reg[0] < adm_pkg::ADM_ATTEN_MIN_FINITE;
  assign o_right_mute = ramp_reg[1] < adm_pkg::ADM_ATTEN_MIN_FINITE;

  // Format and de-emphasis decode
  assign o_audio_format_select = reg18[adm_pkg::ADM_POS_FORMAT +: 3];
  assign o_format_reserved     = o_audio_format_select
                                 >= adm_pkg::ADM_FORMAT_FIRST_RESERVED;
  assign o_ext_filter_format_mode = reg20[adm_pkg::ADM_POS_FILT_BYP];
  assign o_deemph_active = reg18[adm_pkg::ADM_POS_DEEMPH_EN]
                           && !reg20[adm_pkg::ADM_POS_STREAM]
                           && (reg18[adm_pkg::ADM_POS_DEEMPH_RATE +: 2]
                               != 2'h0);
  assign o_deemph_rate_select = o_deemph_active
                                ? reg18[adm_pkg::ADM_POS_DEEMPH_RATE +: 2]
                                : 2'h0;
  assign o_fir_perf_select = reg20[adm_pkg::ADM_POS_STREAM]
                             ? reg18[adm_pkg::ADM_POS_DEEMPH_RATE +: 2]
                             : 2'h0;

  always_comb begin
    o_mode.output_phase_invert     = reg19[adm_pkg::ADM_POS_PHASE_INV];
    o_mode.converter_disable       = reg19[adm_pkg::ADM_POS_CONV_DIS];
    o_mode.zero_flag_pin_select    = reg19[adm_pkg::ADM_POS_ZPIN_SEL];
    o_mode.bypass_stereo_select    = reg19[adm_pkg::ADM_POS_BYP_STEREO];
    o_mode.rolloff_select          = reg19[adm_pkg::ADM_POS_ROLLOFF];
    o_mode.zero_detect_mute_enable = reg19[adm_pkg::ADM_POS_ZMUTE_EN];
    o_mode.one_bit_stream_mode     = reg20[adm_pkg::ADM_POS_STREAM];
    o_mode.filter_bypass           = reg20[adm_pkg::ADM_POS_FILT_BYP];
    o_mode.mono_enable             = reg20[adm_pkg::ADM_POS_MONO];
    o_mode.mono_channel_select     = reg20[adm_pkg::ADM_POS_MONO_CH];
    o_mode.modulator_rate_select   = reg20[adm_pkg::ADM_POS_MOD_RATE +: 2];
    o_mode.stream_zero_output_enable =
      reg21[adm_pkg::ADM_POS_STREAM_ZERO +: 2];
    o_mode.pcm_zero_output_enable  = reg21[adm_pkg::ADM_POS_PCM_ZERO];
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_write_left;
    wr_req && !soft_reset_req
      && (i_word.index == adm_pkg::ADM_IDX_LEFT_ATTEN);
  endsequence

  sequence s_read_req;
    rd_req && (i_word.index == adm_pkg::ADM_IDX_FORMAT);
  endsequence

  a_write_stores: assert property (
    s_write_left |=> bank_reg[0] == $past(i_word.data))
    else $error("Left attenuation write not stored");

  a_read_answer: assert property (
    s_read_req ##0 (wr_req == 1'b0) |=>
      o_rd_valid && (o_rd_data == $past(reg18)))
    else $error("Read answer wrong or late");

  a_ro_flags: assert property (
    wr_req && (i_word.index == adm_pkg::ADM_IDX_ZERO_FLAGS) |=>
      $stable(bank_reg[0]) && $stable(bank_reg[5]) && !o_rd_valid)
    else $error("Write to read-only register had effect");

  a_load_gate: assert property (
    s_write_left ##0 !load_en |=> $stable(applied_reg[0]))
    else $error("Attenuator loaded while loading disabled");

  a_load_pass: assert property (
    s_write_left ##0 load_en |=> applied_reg[0] == $past(i_word.data))
    else $error("Attenuator not loaded while enabled");

  a_atten_scale: assert property (
    o_left_atten_halfdb + o_left_level == adm_pkg::ADM_ATTEN_MAX_CODE)
    else $error("Attenuation scale wrong");

  a_mute_depth: assert property (
    (o_left_level == adm_pkg::ADM_ATTEN_MIN_FINITE) |->
      !o_left_mute && (o_left_atten_halfdb == 8'hf0))
    else $error("Deepest finite attenuation wrong");

  a_mute_range: assert property (
    (o_right_level <= 8'h0e) |-> o_right_mute)
    else $error("Low code did not mute");

  a_deemph_gate: assert property (
    o_deemph_active |-> reg18[adm_pkg::ADM_POS_DEEMPH_EN]
      && (o_deemph_rate_select == reg18[adm_pkg::ADM_POS_DEEMPH_RATE +: 2]))
    else $error("De-emphasis active without enable");

  a_fir_reuse: assert property (
    o_mode.one_bit_stream_mode |-> !o_deemph_active
      && (o_fir_perf_select == reg18[adm_pkg::ADM_POS_DEEMPH_RATE +: 2]))
    else $error("Stream mode filter select wrong");

  a_ramp_step: assert property (
    !step_en && !soft_reset_req |=> $stable(ramp_reg[0]))
    else $error("Ramp moved without a step");

  a_step_rate: assert property (
    step_en && (step_rate == 2'h3) && !soft_reset_req
      |=> (!step_en || (step_rate != 2'h3)) [*8])
    else $error("Step came sooner than rate allows");

  a_zero_flags: assert property (
    rd_req && (i_word.index == adm_pkg::ADM_IDX_ZERO_FLAGS) |=>
      o_rd_data == {6'h00, $past(i_right_zero), $past(i_left_zero)})
    else $error("Zero flag readback wrong");

  a_reserved_zero: assert property (
    o_rd_valid && ($past(i_word.index) == adm_pkg::ADM_IDX_ZERO_OUT)
      |-> o_rd_data[7:3] == 5'h00)
    else $error("Reserved bits read nonzero");

endmodule

// [tb/adm_host_model.sv]
// Host controller model driving the serial control port
`timescale 1ns/100ps
module adm_host_model (
  input  wire logic                  i_clk,
  input  wire logic                  i_rd_valid,
  input  wire logic [7:0]            i_rd_data,
  output logic                       o_word_valid,
  output adm_pkg::adm_word_type      o_word
);
  initial begin
    o_word_valid = 1'b0;
    o_word = '0;
  end

  // Released word lines show the inverse so a stale word never looks live
  task automatic send(input logic rw, input logic [6:0] idx,
                      input logic [7:0] data);
    @(posedge i_clk);
    #1;
    o_word_valid = 1'b1;
    o_word.rw = rw;
    o_word.index = idx;
    o_word.data = data;
    @(posedge i_clk);
    #1;
    o_word_valid = 1'b0;
    o_word = ~o_word;
  endtask

  task automatic read(input logic [6:0] idx, input logic [7:0] junk,
                      output logic [7:0] data, output logic ok);
    int n;
    ok = 1'b0;
    data = 8'h00;
    send(1'b1, idx, junk);
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_rd_valid === 1'b1) begin
        ok = 1'b1;
        data = i_rd_data;
      end else begin
        @(posedge i_clk);
        #1;
      end
    end
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the mode control register bank
`timescale 1ns/100ps
`define ADM_CHECK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("[FAIL] %0t: got %h exp %h", $time, (got), (exp)); \
    end \
  end
module testbench;
  logic i_clk, i_rstn, word_valid, tick, l_zero, r_zero, rd_valid, ok;
  logic format_res, ext_mode, dm_act, mute_l, mute_r, soft_system_reset_pulse;
  logic [7:0] rd_data, got, lvl_l, lvl_r, db_l, db_r;
  logic [2:0] format_sel;
  logic [1:0] dm_rate, fir;
  adm_pkg::adm_word_type word;
  adm_pkg::adm_mode_type mode;
  int failures, checked;
  logic [7:0] defaults [0:5] = '{8'hff, 8'hff, 8'h50, 8'h00, 8'h00, 8'h01};

  adm_host_model host_u (.i_clk(i_clk), .i_rd_valid(rd_valid),
    .i_rd_data(rd_data), .o_word_valid(word_valid), .o_word(word));

  adm_mode_registers dut_u (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_word_valid(word_valid), .i_word(word), .i_word_clk_tick(tick),
    .i_left_zero(l_zero), .i_right_zero(r_zero), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .o_left_level(lvl_l), .o_right_level(lvl_r),
    .o_left_atten_halfdb(db_l), .o_right_atten_halfdb(db_r),
    .o_left_mute(mute_l), .o_right_mute(mute_r),
    .o_audio_format_select(format_sel), .o_format_reserved(format_res),
    .o_ext_filter_format_mode(ext_mode), .o_deemph_active(dm_act),
    .o_deemph_rate_select(dm_rate), .o_fir_perf_select(fir),
    .o_soft_reset_pulse(soft_system_reset_pulse), .o_mode(mode));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Word clock tick once every four system clocks keeps ramps short
  initial begin
    tick = 1'b0;
    forever begin
      repeat (3) @(posedge i_clk);
      #1 tick = 1'b1;
      @(posedge i_clk);
      #1 tick = 1'b0;
    end
  end

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    host_u.send(1'b0, idx, d);
  endtask

  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
    host_u.read(idx, 8'h12, got, ok);
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t: no read answer", $time);
    end
    `ADM_CHECK(got, exp)
  endtask

  task automatic wait_lvl(input logic right, input logic [7:0] exp);
    int n;
    for (n = 0; n < 4000 && (right ? lvl_r : lvl_l) !== exp; n++) begin
      @(posedge i_clk);
      #1;
    end
    `ADM_CHECK((right ? lvl_r : lvl_l), exp)
    if (n == 4000) wrap_up();
  endtask

  // Ticks between two successive level steps of the left ramp
  task automatic step_ticks(input int exp);
    int n, t;
    logic [7:0] last;
    t = 0;
    last = lvl_l;
    for (n = 0; n < 4000 && lvl_l === last; n++) begin
      @(posedge i_clk);
      #1;
    end
    if (n == 4000) begin
      failures++;
      wrap_up();
    end
    last = lvl_l;
    for (n = 0; n < 4000 && lvl_l === last; n++) begin
      @(posedge i_clk);
      if (tick === 1'b1) t++;
      #1;
    end
    `ADM_CHECK(t, exp)
    if (n == 4000) begin
      failures++;
      wrap_up();
    end
  endtask

  initial begin
    i_rstn = 1'b0;
    l_zero = 1'b0;
    r_zero = 1'b0;
    failures = 0;
    checked = 0;
    repeat (2) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(7'(7'h10 + i), defaults[i]);
    `ADM_CHECK(lvl_l, 8'hff)
    `ADM_CHECK(format_sel, 3'b101)
    `ADM_CHECK(dm_act, 1'b0)
    rd_chk(7'h16, 8'h00);
    l_zero = 1'b1;
    rd_chk(7'h16, 8'h01);
    r_zero = 1'b1;
    rd_chk(7'h16, 8'h03);
    l_zero = 1'b0;
    r_zero = 1'b0;
    wr(7'h16, 8'hff);
    rd_chk(7'h16, 8'h00);
    rd_chk(7'h15, 8'h01);
    rd_chk(7'h05, 8'h00);
    rd_chk(7'h11, 8'hff);
    wr(7'h10, 8'h80);
    rd_chk(7'h10, 8'h80);
    repeat (20) @(posedge i_clk);
    #1;
    `ADM_CHECK(lvl_l, 8'hff)
    wr(7'h12, 8'hd0);
    wr(7'h10, 8'h0f);
    wait_lvl(1'b0, 8'h0f);
    `ADM_CHECK(db_l, 8'hf0)
    `ADM_CHECK(mute_l, 1'b0)
    wr(7'h10, 8'h0e);
    wait_lvl(1'b0, 8'h0e);
    `ADM_CHECK(mute_l, 1'b1)
    wr(7'h11, 8'h80);
    wait_lvl(1'b1, 8'h80);
    `ADM_CHECK(db_r, 8'h7f)
    `ADM_CHECK(mute_r, 1'b0)
    wr(7'h10, 8'hff);
    wait_lvl(1'b0, 8'hff);
    wr(7'h12, 8'hd1);
    for (int r = 0; r < 4; r++) begin
      wr(7'h13, {1'b0, r[1:0], 5'h00});
      step_ticks(1 << r);
    end
    wr(7'h13, 8'h00);
    wait_lvl(1'b0, 8'h00);
    `ADM_CHECK(mute_l, 1'b1)
    wr(7'h12, 8'hd0);
    wait_lvl(1'b0, 8'hff);
    for (int f = 0; f < 8; f++) begin
      wr(7'h12, {1'b1, f[2:0], 4'h0});
      `ADM_CHECK(format_sel, f[2:0])
      `ADM_CHECK(format_res, (f >= 6))
    end
    for (int d = 0; d < 8; d++) begin
      wr(7'h12, {4'hd, d[1:0], d[2], 1'b0});
      `ADM_CHECK(dm_act, (d[2] && d[1:0] != 2'b00))
      `ADM_CHECK(dm_rate, (d[2] ? d[1:0] : 2'b00))
    end
    wr(7'h14, 8'h20);
    for (int d = 0; d < 4; d++) begin
      wr(7'h12, {4'hd, d[1:0], 2'b10});
      `ADM_CHECK(fir, d[1:0])
      `ADM_CHECK(dm_act, 1'b0)
    end
    wr(7'h15, 8'hff);
    rd_chk(7'h15, 8'h07);
    wr(7'h14, 8'h9f);
    rd_chk(7'h14, 8'h1f);
    `ADM_CHECK(ext_mode, 1'b1)
    wr(7'h13, 8'h9f);
    `ADM_CHECK(mode, 15'h7eff)
    wr(7'h14, 8'h40);
    `ADM_CHECK(soft_system_reset_pulse, 1'b1)
    `ADM_CHECK(mode, 15'h0001)
    `ADM_CHECK(ext_mode, 1'b0)
    rd_chk(7'h12, 8'h50);
    rd_chk(7'h11, 8'hff);
    wrap_up();
  end
endmodule
